//--- design/hb16_nonmuxed_host_bus.sv
// top: APB-programmed master for the non-multiplexed 16-bit host bus
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - data and address leave on separate dedicated line groups
// - port runs host-bus cycles only when top mode field is 0x3
// - non-multiplexed variant only when host-bus mode field is 0x1
// - address-latch strobe pulses before data phase; external latch holds address
// - separate read and write strobes mark the data phase
// - one to four peripheral selects, one active per access
// - two byte-lane selects qualify lower or upper data byte
// - byte-lane field 0x1 turns byte selects off, full 16-bit words
// - select config 0x0: latch strobe only, no peripheral select
// - select config 0x1: one select replaces latch strobe
// - select config 0x3: latch strobe plus two selects
// - except in select config 0x0, ready input stretches the cycle while peripheral needs time
// - three and four select configs use 11 and 12 extra lines
// - non-multiplexed address reach narrower than multiplexed
module hb16_nonmuxed_host_bus
    import hb16_pkg::*;
(
    input wire logic clk_sys, // 40 MHz system clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic [7:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped offset
    input wire logic [NUM_LINES-1:0] line_in, // interface line levels
    output logic [NUM_LINES-1:0] line_out, // interface line drive values
    output logic [NUM_LINES-1:0] line_oe // interface line enables
);
    localparam int STRB = STROBE_CYC;

    logic [3:0] top_cfg;
    logic [4:0] hb_cfg;
    logic [3:0] sel_cfg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic done_flag;
    logic refused_flag;
    state_t state;
    req_t cur;
    logic [ADDR_W-1:0] cur_addr;
    logic [DATA_W-1:0] cur_wdata;
    logic [3:0] cnt;
    logic [NUM_LINES-1:0] next_out;
    logic [NUM_LINES-1:0] next_oe;
    logic wr_en;
    logic mapped;
    logic cfg_legal;
    logic mode_ok;
    logic [2:0] cs_count;
    logic ale_used;
    logic rdy_used;
    logic lane_sel_on;
    logic start_req;
    logic accept;
    logic done_set;
    req_t new_req;
    logic [3:0] cs_on;
    logic [31:0] rd_mux;

    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign mapped = (paddr == OFS_TOP) || (paddr == OFS_HB) || (paddr == OFS_HB2)
        || (paddr == OFS_ADDR) || (paddr == OFS_WDATA) || (paddr == OFS_CMD) || (paddr == OFS_STAT);

    always_comb
    begin
        cfg_legal = 1'b1;
        cs_count = 3'd0;
        unique case (sel_cfg)
            CS_ALE: cs_count = 3'd0;
            CS_ONE: cs_count = 3'd1;
            CS_TWO: cs_count = 3'd2;
            CS_ALE_TWO: cs_count = 3'd2;
            CS_THREE: cs_count = 3'd3;
            CS_FOUR: cs_count = 3'd4;
            default: cfg_legal = 1'b0;
        endcase
    end

    // other codes of either mode field park every line undriven
    assign mode_ok = (top_cfg == TOP_MODE_HB16)
        && (hb_cfg[1:0] == HB_MODE_NONMUX) && cfg_legal;
    assign ale_used = (sel_cfg == CS_ALE) || (sel_cfg == CS_ALE_TWO);
    assign rdy_used = (sel_cfg != CS_ALE);
    assign lane_sel_on = !hb_cfg[HB_LANE_OFF_BIT];

    assign new_req.write = pwdata[CMD_WRITE];
    assign new_req.sel = pwdata[CMD_SEL +: 2];
    // with byte selects off every transfer is a full word
    assign new_req.lanes = lane_sel_on ? pwdata[CMD_LANE +: 2] : 2'b11;
    assign start_req = wr_en && (paddr == OFS_CMD) && pwdata[CMD_START];
    assign accept = start_req && (state == ST_IDLE) && mode_ok
        && ({1'b0, new_req.sel} < cs_count || cs_count == 3'd0);
    assign done_set = (state == ST_HOLD);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            top_cfg <= TOP_RST;
            hb_cfg <= HB_RST;
            sel_cfg <= HB2_RST;
            addr_reg <= '0;
            wdata_reg <= '0;
        end
        else if (wr_en)
        begin
            if (paddr == OFS_TOP)
                top_cfg <= pwdata[3:0];
            if (paddr == OFS_HB)
                hb_cfg <= pwdata[4:0];
            if (paddr == OFS_HB2)
                sel_cfg <= pwdata[3:0];
            if (paddr == OFS_ADDR)
                addr_reg <= pwdata[ADDR_W-1:0];
            if (paddr == OFS_WDATA)
                wdata_reg <= pwdata[DATA_W-1:0];
        end
    end

    // a new event wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            done_flag <= 1'b0;
            refused_flag <= 1'b0;
        end
        else
        begin
            if (done_set)
                done_flag <= 1'b1;
            else if (wr_en && paddr == OFS_STAT && pwdata[ST_DONE])
                done_flag <= 1'b0;
            if (start_req && !accept)
                refused_flag <= 1'b1;
            else if (wr_en && paddr == OFS_STAT && pwdata[ST_REFUSED])
                refused_flag <= 1'b0;
        end
    end

    always_comb
    begin
        rd_mux = 32'h00000000;
        unique case (paddr)
            OFS_TOP: rd_mux[3:0] = top_cfg;
            OFS_HB: rd_mux[4:0] = hb_cfg;
            OFS_HB2: rd_mux[3:0] = sel_cfg;
            OFS_ADDR: rd_mux[ADDR_W-1:0] = addr_reg;
            OFS_WDATA: rd_mux[DATA_W-1:0] = wdata_reg;
            OFS_STAT:
            begin
                rd_mux[ST_BUSY] = (state != ST_IDLE);
                rd_mux[ST_DONE] = done_flag;
                rd_mux[ST_MODE] = mode_ok;
                rd_mux[ST_REFUSED] = refused_flag;
                rd_mux[ST_RDATA +: DATA_W] = rdata_reg;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    // read data is captured in the setup phase so prdata comes from a flop
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            prdata <= 32'h00000000;
        else if (psel && !penable)
            prdata <= rd_mux;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            cur <= '0;
            cur_addr <= '0;
            cur_wdata <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (accept)
                    begin
                        cur <= new_req;
                        cur_addr <= addr_reg;
                        cur_wdata <= wdata_reg;
                        cnt <= 4'(STROBE_CYC);
                        state <= ale_used ? ST_ALE : ST_STROBE;
                    end
                ST_ALE:
                    state <= ST_STROBE;
                ST_STROBE:
                    if (cnt != 4'h1)
                        cnt <= cnt - 4'h1;
                    else if (!rdy_used || line_in[L_RDY])
                        state <= ST_HOLD;
                ST_HOLD:
                    state <= ST_IDLE;
            endcase
        end
    end

    // strobes are still active on the lines during the hold cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rdata_reg <= '0;
        else if (state == ST_HOLD && !cur.write)
            rdata_reg <= line_in[DATA_W-1:0];
    end

    assign cs_on = (state == ST_IDLE || cs_count == 3'd0) ? 4'h0 : (4'h1 << cur.sel);

    // all strobes and selects are active low except the latch strobe
    always_comb
    begin
        next_out = '0;
        next_oe = '0;
        if (mode_ok)
        begin
            next_oe[DATA_W-1:0] = {DATA_W{cur.write && state != ST_IDLE}};
            next_out[DATA_W-1:0] = cur_wdata;
            next_oe[L_ALE:16] = '1;
            next_out[27:16] = cur_addr[11:0];
            next_out[L_RD] = !(state == ST_STROBE && !cur.write);
            next_out[L_WR] = !(state == ST_STROBE && cur.write);
            unique case (sel_cfg)
                CS_ALE:
                    next_out[L_ALE] = (state == ST_ALE);
                CS_ONE:
                    next_out[L_ALE] = !cs_on[0];
                CS_TWO:
                begin
                    next_out[L_ALE] = !cs_on[0];
                    next_out[L_CS1] = !cs_on[1];
                end
                CS_ALE_TWO:
                begin
                    next_out[L_ALE] = (state == ST_ALE);
                    next_out[L_CS0_ALT] = !cs_on[0];
                    next_out[L_CS1] = !cs_on[1];
                end
                default:
                begin
                    // the extra lines widen the address and carry select 2, and select 3 only with four selects
                    next_out[L_ALE] = !cs_on[0];
                    next_out[L_CS1] = !cs_on[1];
                    next_out[L_CS0_ALT] = cur_addr[10];
                    next_oe[L_CS2] = 1'b1;
                    next_out[L_CS2] = !cs_on[2];
                    next_oe[L_CS3-1:L_XADDR] = '1;
                    next_out[L_CS3-1:L_XADDR] = cur_addr[20:11];
                    next_oe[L_CS3] = (sel_cfg == CS_FOUR);
                    next_out[L_CS3] = !cs_on[3];
                end
            endcase
            if (lane_sel_on)
            begin
                next_out[L_LANE0] = !(cs_on != 4'h0 || state != ST_IDLE) || !cur.lanes[0];
                next_out[L_LANE1] = !(cs_on != 4'h0 || state != ST_IDLE) || !cur.lanes[1];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            line_out <= '0;
            line_oe <= '0;
        end
        else
        begin
            line_out <= next_out;
            line_oe <= next_oe;
        end
    end

    a_top_mode_gate: assert property (
        @(posedge clk_sys) disable iff (rst)
        (top_cfg != TOP_MODE_HB16) |=> (line_oe == '0))
        else $error("lines driven outside host-bus mode");

    a_nonmux_gate: assert property (
        @(posedge clk_sys) disable iff (rst)
        (hb_cfg[1:0] != HB_MODE_NONMUX) && !start_req |=> (line_oe == '0) && (state == ST_IDLE))
        else $error("lines driven outside non-multiplexed mode");

    a_ale_pulse_once: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state == ST_ALE) && (sel_cfg == CS_ALE) && $stable(sel_cfg)
        |=> line_out[L_ALE] ##1 !line_out[L_ALE])
        else $error("latch strobe is not a single cycle pulse");

    a_read_strobe: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state == ST_STROBE) && !cur.write && mode_ok
        |=> !line_out[L_RD] && line_out[L_WR] && (line_oe[DATA_W-1:0] == '0))
        else $error("read strobe wrong in data phase");

    a_write_data: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state == ST_STROBE) && cur.write && mode_ok
        |=> !line_out[L_WR] && (line_oe[DATA_W-1:0] == '1) && (line_out[DATA_W-1:0] == $past(cur_wdata)))
        else $error("write data not on data lines");

    a_ready_stretch: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state == ST_STROBE) && (cnt == 4'h1) && rdy_used && !line_in[L_RDY] |=> (state == ST_STROBE))
        else $error("cycle ended while ready low");

    a_strobe_length: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state == ST_STROBE) && ($past(state) != ST_STROBE) && !rdy_used && $stable(sel_cfg)
        |-> ##(STRB) (state == ST_HOLD))
        else $error("strobe width differs from minimum");

    a_one_select: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state == ST_STROBE) && (sel_cfg == CS_ONE) && mode_ok |=> !line_out[L_ALE])
        else $error("single select not active in access");

    a_two_select_ale: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state == ST_STROBE) && (sel_cfg == CS_ALE_TWO) && (cur.sel == 2'd1) && mode_ok
        |=> !line_out[L_CS1] && line_out[L_CS0_ALT] && !line_out[L_ALE])
        else $error("second select wrong with latch strobe");

    a_lanes_off: assert property (
        @(posedge clk_sys) disable iff (rst)
        !lane_sel_on && mode_ok && (sel_cfg == CS_ALE) |=> (line_out[L_LANE1:L_LANE0] == $past(cur_addr[9:8])))
        else $error("byte selects driven while disabled");

    a_extra_lines: assert property (
        @(posedge clk_sys) disable iff (rst)
        mode_ok && (sel_cfg == CS_FOUR) |=> line_oe[L_CS3] && line_oe[L_CS2] && (line_oe[L_CS3-1:L_XADDR] == '1))
        else $error("extra lines not enabled for four selects");
endmodule : hb16_nonmuxed_host_bus

//--- design/hb16_pkg.sv
// package: constants and types for the 16-bit host-bus port
package hb16_pkg;
    localparam logic [7:0] OFS_TOP = 8'h00;
    localparam logic [7:0] OFS_HB = 8'h04;
    localparam logic [7:0] OFS_HB2 = 8'h08;
    localparam logic [7:0] OFS_ADDR = 8'h0C;
    localparam logic [7:0] OFS_WDATA = 8'h10;
    localparam logic [7:0] OFS_CMD = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [3:0] TOP_RST = 4'h0;
    localparam logic [4:0] HB_RST = 5'h00;
    localparam logic [3:0] HB2_RST = 4'h0;
    localparam logic [3:0] TOP_MODE_HB16 = 4'h3;
    localparam logic [1:0] HB_MODE_NONMUX = 2'h1;
    localparam int HB_LANE_OFF_BIT = 4;
    localparam logic [3:0] CS_ALE = 4'h0;
    localparam logic [3:0] CS_ONE = 4'h1;
    localparam logic [3:0] CS_TWO = 4'h2;
    localparam logic [3:0] CS_ALE_TWO = 4'h3;
    localparam logic [3:0] CS_FOUR = 4'h5;
    localparam logic [3:0] CS_THREE = 4'h7;
    localparam int CMD_START = 0;
    localparam int CMD_WRITE = 1;
    localparam int CMD_SEL = 2;
    localparam int CMD_LANE = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_MODE = 2;
    localparam int ST_REFUSED = 3;
    localparam int ST_RDATA = 16;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 21;
    localparam int NUM_LINES = 44;
    localparam int L_LANE0 = 24;
    localparam int L_LANE1 = 25;
    localparam int L_CS0_ALT = 26;
    localparam int L_CS1 = 27;
    localparam int L_RD = 28;
    localparam int L_WR = 29;
    localparam int L_ALE = 30;
    localparam int L_CS2 = 31;
    localparam int L_RDY = 32;
    localparam int L_XADDR = 33;
    localparam int L_CS3 = 43;
    localparam int CLK_MHZ = 40;
    localparam int STROBE_NS = 50;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {ST_IDLE, ST_ALE, ST_STROBE, ST_HOLD} state_t;
    typedef struct packed {
        logic write;
        logic [1:0] sel;
        logic [1:0] lanes;
    } req_t;
endpackage : hb16_pkg

//--- testbench/hb16_periph_model.sv
// partner: external peripheral with address latch, ready and byte lanes
`timescale 1ns/1ps
module hb16_periph_model
    import hb16_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic [NUM_LINES-1:0] line_out, // port drive values
    input wire logic [NUM_LINES-1:0] line_oe, // port enables
    input wire logic use_latch, // address comes from the latch strobe
    input wire logic lanes_on, // byte selects in use
    input wire logic [31:0] wait_cyc, // ready-low cycles per strobe
    output logic [NUM_LINES-1:0] line_in // wire levels seen by the port
);
    logic [15:0] mem [256];
    logic [7:0] held;
    logic [15:0] last;
    int cnt;
    wire rd_low = line_oe[L_RD] && !line_out[L_RD];
    wire wr_low = line_oe[L_WR] && !line_out[L_WR];
    wire [7:0] adr = use_latch ? held : line_out[23:16];
    wire lo_en = !lanes_on || !line_out[L_LANE0];
    wire hi_en = !lanes_on || !line_out[L_LANE1];
    always @(posedge clk_sys)
    begin
        if (use_latch && line_oe[L_ALE] && line_out[L_ALE])
            held <= line_out[23:16];
        cnt <= (rd_low || wr_low) ? cnt + 1 : 0;
        if (wr_low && lo_en)
            mem[adr][7:0] <= line_out[7:0];
        if (wr_low && hi_en)
            mem[adr][15:8] <= line_out[15:8];
        if (rd_low)
            last <= mem[adr];
    end
    // released data lines show the inverse of the last value, not a held copy
    always_comb
    begin
        line_in = line_out & line_oe;
        line_in[15:0] = rd_low ? mem[adr] : (line_oe[0] ? line_out[15:0] : ~last);
        line_in[L_RDY] = !((rd_low || wr_low) && cnt < wait_cyc);
    end
endmodule : hb16_periph_model

//--- testbench/testbench.sv
// testbench: APB-driven host-bus cycles against a peripheral model
`timescale 1ns/1ps
module testbench
    import hb16_pkg::*;
;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, use_latch, lanes_on, rerr;
    logic [7:0] paddr, seen_a;
    logic [31:0] pwdata, prdata, rdat;
    logic [NUM_LINES-1:0] line_in, line_out, line_oe;
    logic [15:0] exp_mem [int];
    logic [15:0] seen_d;
    logic [3:0] sel_low;
    logic [1:0] seen_ln;
    int wait_cyc, cfg, rd_len, wr_len, ale_n, seed, mismatches, n_tests, cyc;
    int cl [6] = '{0, 1, 2, 3, 5, 7};
    hb16_nonmuxed_host_bus hb16_nonmuxed_host_bus_inst (.clk_sys(clk_sys), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in(line_in), .line_out(line_out), .line_oe(line_oe));
    hb16_periph_model hb16_periph_model_inst (.clk_sys(clk_sys), .line_out(line_out), .line_oe(line_oe),
        .use_latch(use_latch), .lanes_on(lanes_on), .wait_cyc(wait_cyc), .line_in(line_in));
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    function automatic logic lo(input int i);
        return line_oe[i] && !line_out[i];
    endfunction : lo
    function automatic logic [3:0] vmask(input int c);
        return c == 5 ? 4'hF : c == 7 ? 4'h7 : (c == 2 || c == 3) ? 4'h3 : c == 1 ? 4'h1 : 4'h0;
    endfunction : vmask
    // bus watcher: strobe lengths, latch pulses and select levels per cycle
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc >= 30000)
        begin
            mismatches++;
            report_and_stop();
        end
        if (lo(L_RD))
            rd_len++;
        if (lo(L_WR))
            wr_len++;
        if ((cfg == 0 || cfg == 3) && line_oe[L_ALE] && line_out[L_ALE])
            ale_n++;
        if (lo(L_RD) || lo(L_WR))
        begin
            sel_low |= {lo(L_CS3), lo(L_CS2), lo(L_CS1), lo(cfg == 3 ? L_CS0_ALT : L_ALE)};
            seen_a = line_out[23:16];
            seen_d = line_out[15:0];
            seen_ln = line_out[L_LANE1:L_LANE0];
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic setup(input logic [3:0] top, input logic [4:0] hb, input int c, input logic ok);
        apb(1'b1, OFS_TOP, {28'h0, top});
        apb(1'b1, OFS_HB, {27'h0, hb});
        apb(1'b1, OFS_HB2, c);
        cfg = c;
        use_latch = (c == 0 || c == 3);
        lanes_on = !hb[HB_LANE_OFF_BIT];
        apb(1'b0, OFS_STAT, 32'h0);
        chk("mode ok", ok, rdat[ST_MODE]);
        chk("no slave error", 32'h0, rerr);
    endtask : setup
    task automatic op(input logic wr, input logic [7:0] a, input logic [15:0] d, input int sel,
        input logic [1:0] ln, input int wt);
        logic [15:0] e;
        int k;
        wait_cyc = wt;
        apb(1'b1, OFS_STAT, 32'hA);
        apb(1'b1, OFS_ADDR, {24'h0, a});
        apb(1'b1, OFS_WDATA, {16'h0, d});
        {rd_len, wr_len, ale_n, sel_low} = '0;
        apb(1'b1, OFS_CMD, {26'h0, ln, sel[1:0], wr, 1'b1});
        k = 0;
        rdat = '0;
        while (rdat[ST_DONE] !== 1'b1 && k < 60)
        begin
            apb(1'b0, OFS_STAT, 32'h0);
            k++;
        end
        chk("done", 32'h1, rdat[ST_DONE]);
        e = exp_mem.exists(a) ? exp_mem[a] : 16'h0;
        if (wr)
        begin
            e[7:0] = (ln[0] || !lanes_on) ? d[7:0] : e[7:0];
            e[15:8] = (ln[1] || !lanes_on) ? d[15:8] : e[15:8];
            exp_mem[a] = e;
            chk("data lines", d, seen_d);
        end
        else
            chk("read data", e, rdat[31:16]);
        chk("address lines", a, seen_a);
        chk("other strobe", 0, wr ? rd_len : wr_len);
        if (cfg == 0)
            chk("strobe len", STROBE_CYC, wr ? wr_len : rd_len);
        else
            chk("strobe len ok", 1, (wr ? wr_len : rd_len) inside {[STROBE_CYC + wt:STROBE_CYC + wt + 2]});
        if (use_latch)
            chk("latch pulses", 1, ale_n);
        chk("selects", (4'h1 << sel) & vmask(cfg), sel_low & vmask(cfg));
        if (lanes_on)
            chk("lane lines", {30'h0, ~ln}, {30'h0, seen_ln});
    endtask : op
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    initial
    begin
        logic [7:0] a;
        int n;
        {seed, rst, psel, penable, pwrite, paddr, pwdata} = {32'd5, 1'b1, 43'h0};
        {wait_cyc, cfg, use_latch, lanes_on, mismatches, n_tests, cyc} = '0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, OFS_TOP, 32'h0);
        chk("top reset", TOP_RST, rdat);
        apb(1'b0, OFS_HB, 32'h0);
        chk("hb reset", HB_RST, rdat);
        apb(1'b0, OFS_HB2, 32'h0);
        chk("hb2 reset", HB2_RST, rdat);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", 32'h1, {rdat[30:0], rerr});
        apb(1'b1, OFS_CMD, 32'h1);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("refused idle", 32'h8, rdat[3:0]);
        setup(4'h2, 5'h11, 0, 1'b0);
        setup(4'h3, 5'h10, 0, 1'b0);
        setup(4'h3, 5'h11, 4, 1'b0);
        chk("lines idle", 0, |line_oe);
        for (int i = 0; i < 6; i++)
        begin
            setup(TOP_MODE_HB16, 5'h11, cl[i], 1'b1);
            n = $countones(vmask(cl[i])) > 0 ? $countones(vmask(cl[i])) : 1;
            for (int j = 0; j < 2; j++)
            begin
                a = $random(seed);
                op(1'b1, a, $random(seed), $unsigned($random(seed)) % n, 2'b01, j * 3);
                op(1'b0, a, 16'h0, j % n, 2'b11, $unsigned($random(seed)) % 4);
            end
        end
        apb(1'b1, OFS_CMD, 32'hD);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("refused sel", 1, rdat[ST_REFUSED]);
        setup(TOP_MODE_HB16, 5'h01, CS_ONE, 1'b1);
        a = $random(seed);
        op(1'b1, a, $random(seed), 0, 2'b11, 1);
        op(1'b1, a, $random(seed), 0, 2'b01, 0);
        op(1'b1, a, $random(seed), 0, 2'b10, 2);
        op(1'b0, a, 16'h0, 0, 2'b11, 0);
        apb(1'b1, OFS_STAT, 32'hA);
        wait_cyc = 3;
        apb(1'b1, OFS_CMD, 32'h1);
        apb(1'b1, OFS_CMD, 32'h1);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("refused busy", 1, rdat[ST_REFUSED]);
        repeat (20) @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk("lines after reset", 0, |line_oe);
        apb(1'b0, OFS_HB2, 32'h0);
        chk("hb2 after reset", HB2_RST, rdat);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("status after reset", 32'h0, rdat);
        report_and_stop();
    end
endmodule : testbench
